// ===== lin_chan_pkg.sv
// shared constants and types for the dual single-wire bus channel control
package lin_chan_pkg;
    // ************************************************************
    // sizes
    // ************************************************************
    localparam int NUM_CHAN = 2;
    localparam int CNT_W = 20;
    localparam int CLK_HZ = 25000000;

    // ************************************************************
    // times and derived cycle counts
    // ************************************************************
    localparam int MODE_CHANGE_NS = 10000;
    localparam int NORMAL_INIT_NS = 35000;
    localparam int BUS_WAKE_FILTER_NS = 100000;
    localparam int DOMINANT_TIMEOUT_US = 20000;
    localparam int CLK_NS = 1000000000 / CLK_HZ;
    // least times round up, longest times round down
    localparam int MODE_CHANGE_CYC = (MODE_CHANGE_NS + CLK_NS - 1) / CLK_NS;
    localparam int NORMAL_INIT_CYC = NORMAL_INIT_NS / CLK_NS;
    localparam int BUS_WAKE_FILTER_CYC = (BUS_WAKE_FILTER_NS + CLK_NS - 1) / CLK_NS;
    localparam int DOMINANT_TIMEOUT_CYC = DOMINANT_TIMEOUT_US * (1000 / CLK_NS);
    localparam int POWER_UP_CYC = 4;

    // ************************************************************
    // register map (byte addresses) and reset values
    // ************************************************************
    localparam logic [3:0] CTRL_OFS = 4'h0;
    localparam logic [3:0] STATUS_OFS = 4'h4;
    localparam logic [3:0] EVENT_OFS = 4'h8;
    localparam logic [1:0] CTRL_RESET = 2'h3;
    localparam int STATUS_CHAN_BITS = 8;
    localparam int EVENT_TMO_POS = 0;
    localparam int EVENT_WAKE_POS = 2;

    // ************************************************************
    // types
    // ************************************************************
    typedef enum logic [2:0] {
        MODE_POWER_UP,
        MODE_SLEEP,
        MODE_STANDBY,
        MODE_NORMAL
    } chan_mode_t;

    typedef struct packed {
        logic txd;
        logic mode_select;
        logic bus_rx;
    } chan_pin_in_t;

    typedef struct packed {
        logic bus_drive_oe;
        logic bus_drive;
        logic rxd_oe;
        logic rxd;
        logic term_on;
        logic weak_pullup_on;
    } chan_pin_out_t;

    typedef struct packed {
        logic [3:0] address;
        logic read;
        logic write;
        logic [31:0] writedata;
        logic [3:0] byteenable;
    } avmm_req_t;
endpackage : lin_chan_pkg

// ===== lin_chan_props.sv
// assertions on the channel 0 pins and the register bus of the two-channel mode control
`timescale 1ns/1ps
module lin_chan_props #(
    parameter int MODE_CHANGE_CYCLES = 4,
    parameter int NORMAL_INIT_CYCLES = 6,
    parameter int WAKE_FILTER_CYCLES = 8,
    parameter int DOMINANT_TIMEOUT_CYCLES = 40
) (
    input wire logic core_clk_in,
    input wire logic sys_rst_in,
    input wire lin_chan_pkg::chan_pin_in_t [1:0] chan_pins_in,
    input wire logic over_temp_in,
    input wire logic supply_undervoltage_level_in,
    input wire lin_chan_pkg::chan_pin_out_t [1:0] chan_pins_out,
    input wire lin_chan_pkg::avmm_req_t avmm_req_in,
    input wire logic [31:0] avmm_readdata_out,
    input wire logic avmm_waitrequest_out
);
    import lin_chan_pkg::*;
    // ************************************************************
    // run-length counters on channel 0
    // ************************************************************
    chan_pin_in_t pi;
    chan_pin_out_t po;
    logic [19:0] txd_hi_reg, ot_reg, drv_reg, lo_reg, hi_reg, term_reg, sel_lo_reg, quiet_reg;
    logic [19:0] last_dom_reg;
    assign pi = chan_pins_in[0];
    assign po = chan_pins_out[0];
    function automatic logic [19:0] inc(input logic [19:0] c, input logic on);
        return !on ? 20'h0 : (&c) ? c : c + 20'h1;
    endfunction : inc
    always_ff @(posedge core_clk_in) begin
        txd_hi_reg <= sys_rst_in ? 20'h0 : inc(txd_hi_reg, pi.txd);
        ot_reg <= sys_rst_in ? 20'h0 : inc(ot_reg, over_temp_in);
        drv_reg <= sys_rst_in ? 20'h0 : inc(drv_reg, po.bus_drive_oe);
        lo_reg <= sys_rst_in ? 20'h0 : inc(lo_reg, !pi.bus_rx);
        hi_reg <= sys_rst_in ? 20'h0 : inc(hi_reg, pi.bus_rx);
        term_reg <= sys_rst_in ? 20'h0 : inc(term_reg, po.term_on);
        sel_lo_reg <= sys_rst_in ? 20'h0 : inc(sel_lo_reg, !pi.mode_select);
        quiet_reg <= sys_rst_in ? 20'h0
            : inc(quiet_reg, pi.mode_select && !supply_undervoltage_level_in);
        last_dom_reg <= sys_rst_in ? 20'h0 : (pi.bus_rx && lo_reg != 20'h0) ? lo_reg : last_dom_reg;
    end
    // ************************************************************
    // properties
    // ************************************************************
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (sys_rst_in);
    property p_bus_one_wait;
        (avmm_req_in.read || avmm_req_in.write) && avmm_waitrequest_out |=> !avmm_waitrequest_out;
    endproperty
    a_bus_one_wait: assert property (p_bus_one_wait) else $error("no answer after one wait");
    property p_wait_pulse;
        $fell(avmm_waitrequest_out) |=> avmm_waitrequest_out;
    endproperty
    a_wait_pulse: assert property (p_wait_pulse) else $error("wait low longer than one cycle");
    property p_drive_needs_txd;
        po.bus_drive_oe |-> txd_hi_reg < 20'h8;
    endproperty
    a_drive_needs_txd: assert property (p_drive_needs_txd)
        else $error("bus driven with transmit input high");
    property p_drive_timeout;
        drv_reg <= DOMINANT_TIMEOUT_CYCLES + 4;
    endproperty
    a_drive_timeout: assert property (p_drive_timeout)
        else $error("dominant drive outlasted timeout");
    property p_over_temp_off;
        ot_reg >= 20'h8 |-> !po.bus_drive_oe;
    endproperty
    a_over_temp_off: assert property (p_over_temp_off)
        else $error("bus driven during over-temperature");
    property p_drive_in_normal;
        po.bus_drive_oe |-> po.term_on && !po.weak_pullup_on && !po.bus_drive;
    endproperty
    a_drive_in_normal: assert property (p_drive_in_normal)
        else $error("bus driven outside normal mode");
    property p_sleep_pins;
        po.weak_pullup_on |-> !po.term_on && !po.rxd_oe && !po.bus_drive_oe;
    endproperty
    a_sleep_pins: assert property (p_sleep_pins) else $error("sleep pin state wrong");
    property p_rx_dominant;
        lo_reg >= 20'h8 && term_reg >= 20'h8 && po.term_on |-> po.rxd_oe;
    endproperty
    a_rx_dominant: assert property (p_rx_dominant)
        else $error("receive output high with bus dominant");
    property p_sel_low;
        sel_lo_reg >= MODE_CHANGE_CYCLES + 8 |-> !po.bus_drive_oe && (po.weak_pullup_on || po.rxd_oe);
    endproperty
    a_sel_low: assert property (p_sel_low)
        else $error("low select did not leave normal mode");
    property p_sel_high;
        quiet_reg >= MODE_CHANGE_CYCLES + NORMAL_INIT_CYCLES + 8 && hi_reg >= 20'h8
            |-> po.term_on && !po.weak_pullup_on && !po.rxd_oe;
    endproperty
    a_sel_high: assert property (p_sel_high)
        else $error("high select did not reach normal mode");
    property p_wake;
        $fell(po.weak_pullup_on) && sel_lo_reg >= 20'h8
            |-> po.term_on && po.rxd_oe && last_dom_reg >= WAKE_FILTER_CYCLES;
    endproperty
    a_wake: assert property (p_wake) else $error("bus wake rule broken");
    c_drive: cover property (po.bus_drive_oe ##1 !po.bus_drive_oe);
    c_sleep: cover property ($rose(po.weak_pullup_on));
    c_wake: cover property ($fell(po.weak_pullup_on));
endmodule : lin_chan_props

bind lin_channel_mode_control lin_chan_props #(
    .MODE_CHANGE_CYCLES(MODE_CHANGE_CYCLES), .NORMAL_INIT_CYCLES(NORMAL_INIT_CYCLES),
    .WAKE_FILTER_CYCLES(WAKE_FILTER_CYCLES), .DOMINANT_TIMEOUT_CYCLES(DOMINANT_TIMEOUT_CYCLES)
) lin_chan_props_i (.core_clk_in(core_clk_in), .sys_rst_in(sys_rst_in),
    .chan_pins_in(chan_pins_in), .over_temp_in(over_temp_in),
    .supply_undervoltage_level_in(supply_undervoltage_level_in), .chan_pins_out(chan_pins_out),
    .avmm_req_in(avmm_req_in), .avmm_readdata_out(avmm_readdata_out),
    .avmm_waitrequest_out(avmm_waitrequest_out));

// ===== lin_channel_mode_control.sv
// mode, protection and pin logic for two single-wire bus channels
//
// Decided for this implementation: the address map and the Avalon-MM slave port.
`timescale 1ns/1ps
module lin_channel_mode_control #(
    parameter int MODE_CHANGE_CYCLES = lin_chan_pkg::MODE_CHANGE_CYC,
    parameter int NORMAL_INIT_CYCLES = lin_chan_pkg::NORMAL_INIT_CYC,
    parameter int WAKE_FILTER_CYCLES = lin_chan_pkg::BUS_WAKE_FILTER_CYC,
    parameter int DOMINANT_TIMEOUT_CYCLES = lin_chan_pkg::DOMINANT_TIMEOUT_CYC
) (
    input wire logic core_clk_in,
    input wire logic sys_rst_in,
    input wire lin_chan_pkg::chan_pin_in_t [1:0] chan_pins_in,
    input wire logic over_temp_in,
    input wire logic supply_undervoltage_level_in,
    output lin_chan_pkg::chan_pin_out_t [1:0] chan_pins_out,
    input wire lin_chan_pkg::avmm_req_t avmm_req_in,
    output logic [31:0] avmm_readdata_out,
    output logic avmm_waitrequest_out
);
    import lin_chan_pkg::*;

    localparam int SYNC_W = 3 * NUM_CHAN + 2;
    localparam logic [CNT_W-1:0] MC_CNT = CNT_W'(MODE_CHANGE_CYCLES);
    localparam logic [CNT_W-1:0] WAKE_NORMAL_CNT = CNT_W'(MODE_CHANGE_CYCLES
        + NORMAL_INIT_CYCLES);
    localparam logic [CNT_W-1:0] WF_CNT = CNT_W'(WAKE_FILTER_CYCLES);
    localparam logic [CNT_W-1:0] DT_CNT = CNT_W'(DOMINANT_TIMEOUT_CYCLES);
    localparam logic [CNT_W-1:0] PU_CNT = CNT_W'(POWER_UP_CYC);

    // saturating increment shared by all channel timers
    function automatic logic [CNT_W-1:0] count_up(input logic [CNT_W-1:0] value);
        count_up = (&value) ? value : value + CNT_W'(1);
    endfunction : count_up

    // ************************************************************
    // input synchronisers
    // ************************************************************
    logic [SYNC_W-1:0] pin_raw;
    logic [SYNC_W-1:0] sync1_reg;
    logic [SYNC_W-1:0] sync2_reg;
    logic [SYNC_W-1:0] sync3_reg;
    logic [SYNC_W-1:0] pin_filt_reg;

    always_comb begin
        pin_raw = {supply_undervoltage_level_in, over_temp_in, chan_pins_in};
    end

    // filtered level changes once the second and third stages agree
    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            sync1_reg <= '0;
            sync2_reg <= '0;
            sync3_reg <= '0;
            pin_filt_reg <= '0;
        end else begin
            sync1_reg <= pin_raw;
            sync2_reg <= sync1_reg;
            sync3_reg <= sync2_reg;
            pin_filt_reg <= (sync2_reg & sync3_reg) | (pin_filt_reg & (sync2_reg ^ sync3_reg));
        end
    end

    chan_pin_in_t [1:0] pin_s;
    logic ot_s;
    logic uv_s;

    always_comb begin
        pin_s = pin_filt_reg[3*NUM_CHAN-1:0];
        ot_s = pin_filt_reg[3*NUM_CHAN];
        uv_s = pin_filt_reg[3*NUM_CHAN+1];
    end

    // ************************************************************
    // registers
    // ************************************************************
    logic [1:0] tx_allow_reg;
    logic [1:0] tmo_seen_reg;
    logic [1:0] wake_seen_reg;
    chan_mode_t mode_reg [NUM_CHAN];
    logic [CNT_W-1:0] mode_cnt_reg [NUM_CHAN];
    logic [CNT_W-1:0] dom_cnt_reg [NUM_CHAN];
    logic [CNT_W-1:0] wake_cnt_reg [NUM_CHAN];
    logic [1:0] tmo_fault_reg;
    logic [1:0] lockout_reg;
    logic [1:0] txd_prev_reg;
    logic [1:0] wake_event;
    logic [1:0] tmo_event;

    // ************************************************************
    // mode machine
    // ************************************************************
    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            for (int i = 0; i < NUM_CHAN; i++) begin
                mode_reg[i] <= MODE_POWER_UP;
                mode_cnt_reg[i] <= '0;
            end
        end else begin
            for (int i = 0; i < NUM_CHAN; i++) begin
                case (mode_reg[i])
                    MODE_POWER_UP: begin
                        mode_cnt_reg[i] <= count_up(mode_cnt_reg[i]);
                        if (mode_cnt_reg[i] >= PU_CNT) begin
                            mode_reg[i] <= pin_s[i].mode_select ? MODE_NORMAL : MODE_STANDBY;
                            mode_cnt_reg[i] <= '0;
                        end
                    end
                    MODE_SLEEP, MODE_STANDBY: begin
                        if (!pin_s[i].mode_select) begin
                            mode_cnt_reg[i] <= '0;
                            if (wake_event[i]) begin
                                mode_reg[i] <= MODE_STANDBY;
                            end
                        end else if (mode_cnt_reg[i] + CNT_W'(1) >= WAKE_NORMAL_CNT) begin
                            mode_reg[i] <= MODE_NORMAL;
                            mode_cnt_reg[i] <= '0;
                        end else begin
                            mode_cnt_reg[i] <= count_up(mode_cnt_reg[i]);
                        end
                    end
                    MODE_NORMAL: begin
                        if (pin_s[i].mode_select) begin
                            mode_cnt_reg[i] <= '0;
                        end else if (mode_cnt_reg[i] + CNT_W'(1) >= MC_CNT) begin
                            mode_reg[i] <= MODE_SLEEP;
                            mode_cnt_reg[i] <= '0;
                        end else begin
                            mode_cnt_reg[i] <= count_up(mode_cnt_reg[i]);
                        end
                        // undervoltage drops the channel to standby
                        if (uv_s) begin
                            mode_reg[i] <= MODE_STANDBY;
                            mode_cnt_reg[i] <= '0;
                        end
                    end
                    default: begin
                        mode_reg[i] <= MODE_POWER_UP;
                        mode_cnt_reg[i] <= '0;
                    end
                endcase
            end
        end
    end

    // ************************************************************
    // bus wake filter and stuck-dominant lockout
    // ************************************************************
    always_comb begin
        for (int i = 0; i < NUM_CHAN; i++) begin
            wake_event[i] = (mode_reg[i] == MODE_SLEEP) && !lockout_reg[i]
                && pin_s[i].bus_rx && (wake_cnt_reg[i] >= WF_CNT);
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            lockout_reg <= '0;
            for (int i = 0; i < NUM_CHAN; i++) begin
                wake_cnt_reg[i] <= '0;
            end
        end else begin
            for (int i = 0; i < NUM_CHAN; i++) begin
                if (mode_reg[i] != MODE_SLEEP) begin
                    // sample the bus for the cycle the channel lands in sleep
                    lockout_reg[i] <= !pin_s[i].bus_rx;
                    wake_cnt_reg[i] <= '0;
                end else if (lockout_reg[i]) begin
                    wake_cnt_reg[i] <= '0;
                    if (pin_s[i].bus_rx) begin
                        lockout_reg[i] <= 1'b0;
                    end
                end else if (!pin_s[i].bus_rx) begin
                    wake_cnt_reg[i] <= count_up(wake_cnt_reg[i]);
                end else begin
                    wake_cnt_reg[i] <= '0;
                end
            end
        end
    end

    // ************************************************************
    // dominant timeout guard
    // ************************************************************
    always_comb begin
        for (int i = 0; i < NUM_CHAN; i++) begin
            tmo_event[i] = (mode_reg[i] == MODE_NORMAL) && !tmo_fault_reg[i]
                && !pin_s[i].txd && (dom_cnt_reg[i] + CNT_W'(1) >= DT_CNT);
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            tmo_fault_reg <= '0;
            txd_prev_reg <= '0;
            for (int i = 0; i < NUM_CHAN; i++) begin
                dom_cnt_reg[i] <= '0;
            end
        end else begin
            for (int i = 0; i < NUM_CHAN; i++) begin
                txd_prev_reg[i] <= pin_s[i].txd;
                if (pin_s[i].txd && !txd_prev_reg[i]) begin
                    tmo_fault_reg[i] <= 1'b0;
                    dom_cnt_reg[i] <= '0;
                end else if (mode_reg[i] != MODE_NORMAL || pin_s[i].txd) begin
                    dom_cnt_reg[i] <= '0;
                end else if (tmo_event[i]) begin
                    tmo_fault_reg[i] <= 1'b1;
                end else begin
                    dom_cnt_reg[i] <= count_up(dom_cnt_reg[i]);
                end
            end
        end
    end

    // ************************************************************
    // pin outputs
    // ************************************************************
    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            chan_pins_out <= '0;
        end else begin
            for (int i = 0; i < NUM_CHAN; i++) begin
                chan_pins_out[i].bus_drive <= 1'b0;
                chan_pins_out[i].rxd <= 1'b0;
                chan_pins_out[i].bus_drive_oe <= (mode_reg[i] == MODE_NORMAL)
                    && !pin_s[i].txd && !tmo_fault_reg[i] && !tmo_event[i]
                    && !ot_s && !uv_s && tx_allow_reg[i];
                case (mode_reg[i])
                    MODE_NORMAL: begin
                        chan_pins_out[i].rxd_oe <= !pin_s[i].bus_rx;
                        chan_pins_out[i].term_on <= 1'b1;
                        chan_pins_out[i].weak_pullup_on <= 1'b0;
                    end
                    MODE_STANDBY: begin
                        chan_pins_out[i].rxd_oe <= 1'b1;
                        chan_pins_out[i].term_on <= 1'b1;
                        chan_pins_out[i].weak_pullup_on <= 1'b0;
                    end
                    MODE_SLEEP: begin
                        chan_pins_out[i].rxd_oe <= 1'b0;
                        chan_pins_out[i].term_on <= 1'b0;
                        chan_pins_out[i].weak_pullup_on <= 1'b1;
                    end
                    default: begin
                        chan_pins_out[i].rxd_oe <= 1'b0;
                        chan_pins_out[i].term_on <= 1'b1;
                        chan_pins_out[i].weak_pullup_on <= 1'b0;
                    end
                endcase
            end
        end
    end

    // ************************************************************
    // register bus slave
    // ************************************************************
    logic bus_req;
    logic bus_take;
    logic [31:0] read_value;
    logic [31:0] status_value;

    always_comb begin
        bus_req = avmm_req_in.read || avmm_req_in.write;
        bus_take = bus_req && !avmm_waitrequest_out;
        status_value = '0;
        for (int i = 0; i < NUM_CHAN; i++) begin
            status_value[i*STATUS_CHAN_BITS +: STATUS_CHAN_BITS] = {1'h0,
                uv_s, ot_s, lockout_reg[i], tmo_fault_reg[i], mode_reg[i]};
        end
        case (avmm_req_in.address)
            CTRL_OFS: read_value = {30'h0, tx_allow_reg};
            STATUS_OFS: read_value = status_value;
            EVENT_OFS: read_value = {28'h0, wake_seen_reg, tmo_seen_reg};
            default: read_value = 32'h0;
        endcase
    end

    // one wait cycle, then the answer stands for the sampling edge
    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            avmm_waitrequest_out <= 1'b1;
            avmm_readdata_out <= '0;
        end else if (bus_take) begin
            avmm_waitrequest_out <= 1'b1;
        end else if (bus_req) begin
            avmm_waitrequest_out <= 1'b0;
            avmm_readdata_out <= avmm_req_in.read ? read_value : 32'h0;
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            tx_allow_reg <= CTRL_RESET;
        end else if (bus_take && avmm_req_in.write && avmm_req_in.byteenable[0]
            && avmm_req_in.address == CTRL_OFS) begin
            tx_allow_reg <= avmm_req_in.writedata[1:0];
        end
    end

    // sticky events, write one to clear, a new event wins over the clear
    logic ev_clear;

    always_comb begin
        ev_clear = bus_take && avmm_req_in.write && avmm_req_in.byteenable[0]
            && avmm_req_in.address == EVENT_OFS;
    end

    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            tmo_seen_reg <= '0;
            wake_seen_reg <= '0;
        end else begin
            tmo_seen_reg <= (tmo_seen_reg & ~(ev_clear
                ? avmm_req_in.writedata[EVENT_TMO_POS +: 2] : 2'h0)) | tmo_event;
            wake_seen_reg <= (wake_seen_reg & ~(ev_clear
                ? avmm_req_in.writedata[EVENT_WAKE_POS +: 2] : 2'h0)) | wake_event;
        end
    end
endmodule : lin_channel_mode_control

// ===== lin_channel_mode_control_tb_top.sv
// self-checking bench for the two-channel mode control
`timescale 1ns/1ps
module lin_channel_mode_control_tb_top;
    import lin_chan_pkg::*;
    localparam int BIT_CYC = 1250;
    logic core_clk_in = 1'b0;
    logic sys_rst_in = 1'b1;
    chan_pin_in_t [1:0] pins_in;
    chan_pin_out_t [1:0] pins_out;
    avmm_req_t req = '0;
    logic [31:0] rdata;
    logic wait_req;
    logic over_temp = 1'b0;
    logic undervolt = 1'b0;
    logic [1:0] sel = 2'b01;
    logic [1:0] txd = 2'b11;
    logic [1:0] remote_dom = 2'b00;
    logic part_start = 1'b0;
    logic [7:0] part_byte = 8'h00;
    logic part_txd;
    logic [9:0] frame;
    logic [4:0] pe;
    int error_cnt = 0;
    int check_count = 0;
    int cycles = 0;
    logic [31:0] rd_q[$];
    logic [4:0] pin_q[$];
    // bus wires with pull-ups resolved from all drivers
    assign pins_in[0] = {part_txd & txd[0], sel[0], ~(pins_out[0].bus_drive_oe | remote_dom[0])};
    assign pins_in[1] = {txd[1], sel[1], ~(pins_out[1].bus_drive_oe | remote_dom[1])};
    lin_channel_mode_control #(.MODE_CHANGE_CYCLES(4), .NORMAL_INIT_CYCLES(6),
        .WAKE_FILTER_CYCLES(8), .DOMINANT_TIMEOUT_CYCLES(12000)) lin_channel_mode_control_i (
        .core_clk_in(core_clk_in), .sys_rst_in(sys_rst_in), .chan_pins_in(pins_in),
        .over_temp_in(over_temp), .supply_undervoltage_level_in(undervolt),
        .chan_pins_out(pins_out), .avmm_req_in(req), .avmm_readdata_out(rdata),
        .avmm_waitrequest_out(wait_req));
    lin_host_tx_model #(.BIT_CYC(BIT_CYC)) lin_host_tx_model_i (.core_clk_in(core_clk_in),
        .sys_rst_in(sys_rst_in), .start_in(part_start), .data_in(part_byte), .txd_out(part_txd));
    always #20 core_clk_in = ~core_clk_in;
    // ************************************************************
    // tasks
    // ************************************************************
    task automatic report_and_stop();
        $display("checks=%0d errors=%0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : report_and_stop
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk_in);
    endtask : tick
    task automatic pins(input logic ch, input logic [3:0] e);
        pin_q.push_back({ch, e});
    endtask : pins
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
        if (!wr) rd_q.push_back(d);
        req <= '{address: a, read: !wr, write: wr, writedata: wr ? d : 32'h0, byteenable: 4'hF};
        do @(posedge core_clk_in); while (wait_req);
        req <= '0;
        @(posedge core_clk_in);
    endtask : bus
    task automatic dom_pulse(input int n);
        remote_dom[0] <= 1'b1;
        tick(n);
        remote_dom[0] <= 1'b0;
        tick(20);
    endtask : dom_pulse
    // ************************************************************
    // monitors and watchdog
    // ************************************************************
    always @(posedge core_clk_in) begin
        if (req.read && !wait_req) check(rdata, rd_q.pop_front());
    end
    always @(negedge core_clk_in) begin
        while (pin_q.size() > 0) begin
            pe = pin_q.pop_front();
            check({28'h0, pins_out[pe[4]].bus_drive_oe, pins_out[pe[4]].rxd_oe,
                pins_out[pe[4]].term_on, pins_out[pe[4]].weak_pullup_on}, {28'h0, pe[3:0]});
        end
    end
    always @(posedge core_clk_in) begin
        cycles++;
        if (cycles == 40000) begin
            error_cnt++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, cycles, 0);
            report_and_stop();
        end
    end
    // ************************************************************
    // main sequence
    // ************************************************************
    initial begin
        void'($urandom(32'h495B));
        tick(6);
        sys_rst_in <= 1'b0;
        tick(40);
        pins(0, 4'h2);
        pins(1, 4'h6);
        bus(0, CTRL_OFS, 32'h3);
        bus(0, STATUS_OFS, 32'h0000_0203);
        bus(0, 4'hC, 32'h0);
        part_byte <= 8'($urandom);
        part_start <= 1'b1;
        tick(1);
        part_start <= 1'b0;
        frame = {1'b1, part_byte, 1'b0};
        tick(BIT_CYC / 2);
        for (int k = 0; k < 10; k++) begin
            pins(0, {~frame[k], ~frame[k], 2'b10});
            tick(BIT_CYC);
        end
        txd[1] <= 1'b0;
        tick(20);
        pins(1, 4'h6);
        txd <= 2'b10;
        tick(20);
        pins(0, 4'hE);
        tick(12000);
        pins(0, 4'h2);
        bus(0, EVENT_OFS, 32'h1);
        bus(1, EVENT_OFS, 32'h1);
        bus(0, EVENT_OFS, 32'h0);
        txd[0] <= 1'b1;
        tick(10);
        txd[0] <= 1'b0;
        tick(20);
        pins(0, 4'hE);
        txd[0] <= 1'b1;
        over_temp <= 1'b1;
        tick(10);
        txd[0] <= 1'b0;
        tick(15);
        pins(0, 4'h2);
        over_temp <= 1'b0;
        tick(15);
        pins(0, 4'hE);
        txd[0] <= 1'b1;
        bus(1, CTRL_OFS, ($urandom & 32'hFFFF_FFFC) | 32'h2);
        bus(0, CTRL_OFS, 32'h2);
        bus(1, CTRL_OFS, 32'h3);
        sel[0] <= 1'b0;
        tick(30);
        pins(0, 4'h1);
        dom_pulse(4);
        pins(0, 4'h1);
        dom_pulse(16);
        pins(0, 4'h6);
        bus(0, EVENT_OFS, 32'h4);
        bus(1, EVENT_OFS, 32'h4);
        sel[0] <= 1'b1;
        tick(30);
        pins(0, 4'h2);
        remote_dom[0] <= 1'b1;
        sel[0] <= 1'b0;
        tick(50);
        pins(0, 4'h1);
        remote_dom[0] <= 1'b0;
        tick(20);
        pins(0, 4'h1);
        dom_pulse(16);
        pins(0, 4'h6);
        sel[1] <= 1'b1;
        tick(30);
        pins(1, 4'h2);
        sel[1] <= 1'b0;
        tick(30);
        pins(1, 4'h1);
        sel[1] <= 1'b1;
        tick(30);
        pins(1, 4'h2);
        undervolt <= 1'b1;
        tick(20);
        pins(1, 4'h6);
        undervolt <= 1'b0;
        tick(30);
        pins(1, 4'h2);
        pins(0, 4'h6);
        tick(5);
        report_and_stop();
    end
endmodule : lin_channel_mode_control_tb_top

// ===== lin_host_tx_model.sv
// host transmitter model sending one byte on the transmit line at a fixed bit time
`timescale 1ns/1ps
module lin_host_tx_model #(
    parameter int BIT_CYC = 1250
) (
    input wire logic core_clk_in,
    input wire logic sys_rst_in,
    input wire logic start_in,
    input wire logic [7:0] data_in,
    output logic txd_out
);
    logic [9:0] frame_reg = 10'h3FF;
    logic [3:0] bit_reg = 4'h0;
    logic [11:0] cyc_reg = 12'h0;
    logic busy_reg = 1'b0;
    assign txd_out = busy_reg ? frame_reg[bit_reg] : 1'b1;
    // one bit per BIT_CYC clocks, idle recessive
    always @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            busy_reg <= 1'b0;
        end else if (!busy_reg) begin
            busy_reg <= start_in;
            frame_reg <= {1'b1, data_in, 1'b0};
            bit_reg <= 4'h0;
            cyc_reg <= 12'h0;
        end else if (cyc_reg != 12'(BIT_CYC - 1)) begin
            cyc_reg <= cyc_reg + 12'h1;
        end else begin
            cyc_reg <= 12'h0;
            bit_reg <= bit_reg + 4'h1;
            busy_reg <= (bit_reg != 4'h9);
        end
    end
endmodule : lin_host_tx_model
